// >>> inc/alc_pkg.sv
package alc_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int TAG_W = 3;
  localparam int PTR_W = 4;
  localparam int NUM_CH = 8;
  localparam int NUM_LIMIT_CH = 4;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [PTR_W-1:0] IDX_RESULT = 4'h0;
  localparam logic [PTR_W-1:0] IDX_STATUS = 4'h1;
  localparam logic [PTR_W-1:0] IDX_CFG = 4'h2;
  localparam logic [PTR_W-1:0] IDX_TIMER = 4'h3;
  localparam logic [PTR_W-1:0] IDX_LIMIT_BASE = 4'h4;
  localparam logic [PTR_W-1:0] LIMIT_STRIDE = 4'h3;

  // limit register kinds within one channel's group of three
  localparam logic [1:0] LIM_LOWER = 2'h0;
  localparam logic [1:0] LIM_UPPER = 2'h1;
  localparam logic [1:0] LIM_HYST = 2'h2;

  // ---------------------------------------------------------------
  // field layouts and reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] CFG_RESET = 12'h008;
  localparam int CFG_POL_BIT = 0;
  localparam int CFG_FN_LSB = 1;
  localparam int CFG_FLTR_BIT = 3;
  localparam int CFG_CH_LSB = 4;
  localparam logic [1:0] PIN_NONE = 2'h0;
  localparam logic [1:0] PIN_BUSY = 2'h1;
  localparam logic [1:0] PIN_ALERT = 2'h2;
  localparam logic [1:0] PIN_RESET = 2'h3;
  localparam logic [7:0] STATUS_CLEAR_ALL = 8'hff;
  localparam logic [DATA_W-1:0] HYST_RESET_10 = 12'h002;
  localparam logic [DATA_W-1:0] HYST_RESET_12 = 12'h008;
  localparam logic [DATA_W-1:0] MASK_10 = 12'hffc;
  localparam logic [DATA_W-1:0] MASK_12 = 12'hfff;

  // meaningful data bits; also the full-scale code of the variant
  function automatic logic [DATA_W-1:0] alc_data_mask(input int res_bits);
    return (res_bits == 10) ? MASK_10 : MASK_12;
  endfunction

  function automatic logic [DATA_W-1:0] alc_hyst_reset(input int res_bits);
    return (res_bits == 10) ? HYST_RESET_10 : HYST_RESET_12;
  endfunction

endpackage

// >>> inc/alc_chk_if.sv
`timescale 1ns/100ps
// one channel's limits and sample toward its checker, alert state back
interface alc_chk_if;
  import alc_pkg::*;
  logic [DATA_W-1:0] upper;
  logic [DATA_W-1:0] lower;
  logic [DATA_W-1:0] hyst;
  logic sample_valid;
  logic [DATA_W-1:0] sample;
  logic clear_all;
  logic hi_active;
  logic lo_active;
  logic hi_event;
  logic lo_event;

  modport chk (
    input upper, lower, hyst, sample_valid, sample, clear_all,
    output hi_active, lo_active, hi_event, lo_event
  );
  modport ctl (
    output upper, lower, hyst, sample_valid, sample, clear_all,
    input hi_active, lo_active, hi_event, lo_event
  );
endinterface

// >>> hw/alc_limit_chk.sv
`timescale 1ns/100ps
module alc_limit_chk
  import alc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // limits, sample and alert state
  alc_chk_if.chk port
);

  logic over;
  logic under;
  logic hi_release;
  logic lo_release;

  // ---------------------------------------------------------------
  // comparisons
  // ---------------------------------------------------------------
  // differences are taken only when non-negative, so no wrap at zero
  always_comb
  begin
    over = port.sample > port.upper;
    under = port.sample < port.lower;
    hi_release = !over && ((port.upper - port.sample) >= port.hyst);
    lo_release = !under && ((port.sample - port.lower) >= port.hyst);
  end

  // ---------------------------------------------------------------
  // alert state
  // ---------------------------------------------------------------
  // a violating sample wins over a clear arriving in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      port.hi_active <= 1'b0;
      port.lo_active <= 1'b0;
    end
    else
    begin
      if (port.sample_valid && over)
        port.hi_active <= 1'b1;
      else if (port.clear_all || (port.sample_valid && hi_release))
        port.hi_active <= 1'b0;
      if (port.sample_valid && under)
        port.lo_active <= 1'b1;
      else if (port.clear_all || (port.sample_valid && lo_release))
        port.lo_active <= 1'b0;
    end
  end

  // one-cycle events feed the sticky status bits
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      port.hi_event <= 1'b0;
      port.lo_event <= 1'b0;
    end
    else
    begin
      port.hi_event <= port.sample_valid && over;
      port.lo_event <= port.sample_valid && under;
    end
  end

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_hi_hold: assert property (port.hi_active && !port.clear_all && port.sample_valid
    && !over && !hi_release |=> port.hi_active)
    else $error("upper alert released inside hysteresis band");
  a_lo_set: assert property (port.sample_valid && under |=> port.lo_active ##0 port.lo_event)
    else $error("lower violation did not raise alert");

endmodule

// >>> hw/alc_result_limit.sv
`timescale 1ns/100ps
module alc_result_limit
  import alc_pkg::*;
#(
  parameter int RES_BITS = 12
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port, byte wide
  input wire logic ptr_load,
  input wire logic [PTR_W-1:0] ptr_value,
  input wire logic wr_en,
  input wire logic [7:0] wr_byte,
  input wire logic rd_en,
  output logic [7:0] rd_byte,
  // converter side
  input wire logic conv_busy,
  input wire logic res_valid,
  input wire logic [TAG_W-1:0] res_channel,
  input wire logic [DATA_W-1:0] res_data,
  // configuration outputs
  output logic [NUM_CH-1:0] cfg_channel_sel,
  output logic cfg_filter_en,
  output logic [7:0] cycle_timer,
  // shared interrupt pin
  output logic int_pin
);

  localparam logic [DATA_W-1:0] DMASK = alc_data_mask(RES_BITS);
  localparam logic [DATA_W-1:0] HYST_INIT = alc_hyst_reset(RES_BITS);

  logic [PTR_W-1:0] ptr;
  logic phase;
  logic [7:0] wr_stage;
  logic [7:0] rd_low;
  logic [DATA_W-1:0] cfg;
  logic [7:0] status;
  logic [TAG_W-1:0] result_tag;
  logic [DATA_W-1:0] result_data;
  logic [DATA_W-1:0] upper [NUM_LIMIT_CH];
  logic [DATA_W-1:0] lower [NUM_LIMIT_CH];
  logic [DATA_W-1:0] hyst [NUM_LIMIT_CH];
  logic [NUM_LIMIT_CH-1:0] hi_act;
  logic [NUM_LIMIT_CH-1:0] lo_act;
  logic [7:0] status_set;
  logic alert_any;
  logic wr_ok;
  logic rd_ok;
  logic wr_commit;
  logic [15:0] wr_word;
  logic [15:0] rd_word;
  logic cfg_clear;
  logic status_clear;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_byte_reg(input logic [PTR_W-1:0] idx);
    return (idx == IDX_STATUS) || (idx == IDX_TIMER);
  endfunction

  function automatic logic [1:0] lim_ch(input logic [PTR_W-1:0] idx);
    logic [PTR_W-1:0] off;
    off = idx - IDX_LIMIT_BASE;
    return 2'(off / LIMIT_STRIDE);
  endfunction

  function automatic logic [1:0] lim_kind(input logic [PTR_W-1:0] idx);
    logic [PTR_W-1:0] off;
    off = idx - IDX_LIMIT_BASE;
    return 2'(off % LIMIT_STRIDE);
  endfunction

  // ---------------------------------------------------------------
  // register port sequencing
  // ---------------------------------------------------------------
  // a pointer load in the same cycle as a byte access drops the access
  assign wr_ok = wr_en && !ptr_load;
  assign rd_ok = rd_en && !ptr_load;
  assign wr_commit = wr_ok && (is_byte_reg(ptr) || phase);
  assign wr_word = is_byte_reg(ptr) ? {8'h00, wr_byte} : {wr_stage, wr_byte};

  // pointer and byte phase; sixteen-bit registers go high byte first
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ptr <= IDX_RESULT;
      phase <= 1'b0;
    end
    else if (ptr_load)
    begin
      ptr <= ptr_value;
      phase <= 1'b0;
    end
    else if ((wr_ok || rd_ok) && !is_byte_reg(ptr))
      phase <= !phase;
  end

  // first written byte waits here until its partner arrives
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wr_stage <= 8'h00;
    else if (wr_ok && !phase)
      wr_stage <= wr_byte;
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_word = 16'h0000;
    if (ptr == IDX_RESULT)
      rd_word = {alert_any, result_tag, result_data};
    else if (ptr == IDX_STATUS)
      rd_word = {8'h00, status};
    else if (ptr == IDX_CFG)
      rd_word = {4'h0, cfg};
    else if (ptr == IDX_TIMER)
      rd_word = {8'h00, cycle_timer};
    else if (lim_kind(ptr) == LIM_LOWER)
      rd_word = {4'h0, lower[lim_ch(ptr)]};
    else if (lim_kind(ptr) == LIM_UPPER)
      rd_word = {4'h0, upper[lim_ch(ptr)]};
    else
      rd_word = {4'h0, hyst[lim_ch(ptr)]};
  end

  // low byte is snapshot with the high one so a new result cannot tear the word
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_byte <= 8'h00;
      rd_low <= 8'h00;
    end
    else if (rd_ok)
    begin
      if (is_byte_reg(ptr))
        rd_byte <= rd_word[7:0];
      else if (!phase)
      begin
        rd_byte <= rd_word[15:8];
        rd_low <= rd_word[7:0];
      end
      else
        rd_byte <= rd_low;
    end
  end

  // ---------------------------------------------------------------
  // configuration and cycle timer
  // ---------------------------------------------------------------
  assign cfg_clear = wr_commit && (ptr == IDX_CFG)
    && (wr_word[CFG_FN_LSB+:2] == PIN_RESET);

  // the reset code is remembered as plain alert mode
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cfg <= CFG_RESET;
    else if (wr_commit && (ptr == IDX_CFG))
    begin
      cfg <= wr_word[DATA_W-1:0];
      if (cfg_clear)
        cfg[CFG_FN_LSB+:2] <= PIN_ALERT;
    end
  end

  // timer is only stored here; the interval logic lives elsewhere
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cycle_timer <= 8'h00;
    else if (wr_commit && (ptr == IDX_TIMER))
      cycle_timer <= wr_word[7:0];
  end

  assign cfg_channel_sel = cfg[CFG_CH_LSB+:NUM_CH];
  assign cfg_filter_en = cfg[CFG_FLTR_BIT];

  // ---------------------------------------------------------------
  // result word
  // ---------------------------------------------------------------
  // low bits are forced to zero in the narrow variant
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      result_tag <= '0;
      result_data <= '0;
    end
    else if (res_valid)
    begin
      result_tag <= res_channel;
      result_data <= res_data & DMASK;
    end
  end

  // ---------------------------------------------------------------
  // limit registers
  // ---------------------------------------------------------------
  // writes are kept as given; narrow-variant software zeroes the low bits
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_LIMIT_CH; i++)
      begin
        upper[i] <= DMASK;
        lower[i] <= '0;
        hyst[i] <= HYST_INIT;
      end
    end
    else if (wr_commit && (ptr >= IDX_LIMIT_BASE))
    begin
      if (lim_kind(ptr) == LIM_LOWER)
        lower[lim_ch(ptr)] <= wr_word[DATA_W-1:0];
      else if (lim_kind(ptr) == LIM_UPPER)
        upper[lim_ch(ptr)] <= wr_word[DATA_W-1:0];
      else
        hyst[lim_ch(ptr)] <= wr_word[DATA_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // per-channel checkers
  // ---------------------------------------------------------------
  alc_chk_if chk [NUM_LIMIT_CH] ();

  for (genvar g = 0; g < NUM_LIMIT_CH; g++)
  begin : g_chk
    assign chk[g].upper = upper[g];
    assign chk[g].lower = lower[g];
    assign chk[g].hyst = hyst[g];
    // channels above the fourth never reach a checker
    assign chk[g].sample_valid = res_valid && (res_channel == TAG_W'(g));
    assign chk[g].sample = res_data & DMASK;
    assign chk[g].clear_all = cfg_clear;
    assign hi_act[g] = chk[g].hi_active;
    assign lo_act[g] = chk[g].lo_active;
    assign status_set[2*g] = chk[g].lo_event;
    assign status_set[2*g+1] = chk[g].hi_event;
    alc_limit_chk u_chk (
      .ref_clk(ref_clk),
      .rst(rst),
      .port(chk[g].chk)
    );
  end

  assign alert_any = |{hi_act, lo_act};

  // ---------------------------------------------------------------
  // alert status, sticky
  // ---------------------------------------------------------------
  assign status_clear = cfg_clear
    || (wr_commit && (ptr == IDX_STATUS) && (wr_word[7:0] == STATUS_CLEAR_ALL));

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      status <= 8'h00;
    else
      status <= status_set | (status_clear ? 8'h00 : status);
  end

  // ---------------------------------------------------------------
  // shared interrupt pin
  // ---------------------------------------------------------------
  // one cycle behind its source so the pin comes straight off a flop
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      int_pin <= !CFG_RESET[CFG_POL_BIT];
    else
    begin
      case (cfg[CFG_FN_LSB+:2])
        PIN_BUSY: int_pin <= conv_busy ~^ cfg[CFG_POL_BIT];
        PIN_ALERT: int_pin <= alert_any ~^ cfg[CFG_POL_BIT];
        default: int_pin <= !cfg[CFG_POL_BIT];
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_cfg_code_readback: assert property (cfg_clear |=> cfg[CFG_FN_LSB+:2] == PIN_ALERT)
    else $error("reset code not read back as alert mode");
  a_clear_all_alerts: assert property (cfg_clear && !(|status_set) && !res_valid
    |=> status == 8'h00 && !alert_any)
    else $error("reset code left alert state behind");
  a_status_ones_clear: assert property (status_clear && !cfg_clear
    |=> status == $past(status_set))
    else $error("status write of all ones did not clear");
  a_pin_busy_level: assert property (cfg[CFG_FN_LSB+:2] == PIN_BUSY && $stable(cfg)
    |=> int_pin == ($past(conv_busy) ~^ $past(cfg[CFG_POL_BIT])))
    else $error("busy pin level wrong");
  a_pin_idle_level: assert property (cfg[CFG_FN_LSB+:2] == PIN_NONE
    |=> int_pin == !$past(cfg[CFG_POL_BIT]))
    else $error("idle pin not inactive");
  a_high_set_flag: assert property (res_valid && res_channel < TAG_W'(NUM_LIMIT_CH)
    && (res_data & DMASK) > upper[res_channel[1:0]] |=> alert_any)
    else $error("upper violation did not raise flag");
  a_far_ch_quiet: assert property (res_valid && res_channel >= TAG_W'(NUM_LIMIT_CH)
    && !cfg_clear |=> $stable(hi_act) && $stable(lo_act))
    else $error("channel without limits changed alert state");
  a_limit_top_zero: assert property (rd_ok && !phase && ptr >= IDX_LIMIT_BASE
    |=> rd_byte[7:4] == 4'h0)
    else $error("limit register top nibble not zero");
  a_result_layout: assert property (res_valid |=> result_tag == $past(res_channel)
    && result_data[1:0] == ($past(res_data[1:0]) & DMASK[1:0]))
    else $error("result word not stored as given");

  c_alert_raised: cover property (res_valid ##1 alert_any ##1 int_pin);
  c_reset_code: cover property (alert_any ##[1:20] cfg_clear);
  c_two_byte_read: cover property (rd_ok && !phase && ptr == IDX_RESULT ##1 rd_ok);

endmodule

// >>> sim/alc_host_model.sv
`timescale 1ns/100ps
// byte-level register master standing in for the serial host
module alc_host_model
  import alc_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register port toward the device
  output logic ptr_load,
  output logic [PTR_W-1:0] ptr_value,
  output logic wr_en,
  output logic [7:0] wr_byte,
  output logic rd_en,
  input wire logic [7:0] rd_byte
);
  // ---------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------
  initial
  begin
    ptr_load = 1'b0;
    ptr_value = 4'h0;
    wr_en = 1'b0;
    wr_byte = 8'h00;
    rd_en = 1'b0;
  end

  // ---------------------------------------------------------------
  // accesses, all launched on the falling edge
  // ---------------------------------------------------------------
  // a pointer load restarts the byte phase, so every word starts clean
  task automatic set_ptr(input logic [PTR_W-1:0] idx);
    @(negedge ref_clk);
    ptr_load = 1'b1;
    ptr_value = idx;
    @(negedge ref_clk);
    ptr_load = 1'b0;
  endtask

  // two-byte write, high byte first; limit writes zero the low two bits for the narrow part
  task automatic wr16(input logic [PTR_W-1:0] idx, input logic [15:0] v);
    set_ptr(idx);
    wr_en = 1'b1;
    wr_byte = v[15:8];
    @(negedge ref_clk);
    wr_byte = (idx >= IDX_LIMIT_BASE) ? {v[7:2], 2'h0} : v[7:0];
    @(negedge ref_clk);
    wr_en = 1'b0;
    wr_byte = ~wr_byte; // released data never shows the last byte
  endtask

  task automatic wr8(input logic [PTR_W-1:0] idx, input logic [7:0] v);
    set_ptr(idx);
    wr_en = 1'b1;
    wr_byte = v;
    @(negedge ref_clk);
    wr_en = 1'b0;
    wr_byte = ~v;
  endtask

  // rd_en held over two edges asks for both bytes back to back
  task automatic rd16(input logic [PTR_W-1:0] idx, output logic [15:0] v);
    set_ptr(idx);
    rd_en = 1'b1;
    @(negedge ref_clk);
    v[15:8] = rd_byte;
    @(negedge ref_clk);
    v[7:0] = rd_byte;
    rd_en = 1'b0;
  endtask

  task automatic rd8(input logic [PTR_W-1:0] idx, output logic [7:0] v);
    set_ptr(idx);
    rd_en = 1'b1;
    @(negedge ref_clk);
    v = rd_byte;
    rd_en = 1'b0;
  endtask
endmodule

// >>> sim/alc_result_limit_tb_top.sv
`timescale 1ns/100ps
// self-checking bench for result formatting and limit alerts
module alc_result_limit_tb_top;
  import alc_pkg::*;
  // ---------------------------------------------------------------
  // signals and reference state
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic conv_busy = 1'b0;
  logic res_valid = 1'b0;
  logic [TAG_W-1:0] res_channel = 3'h0;
  logic [DATA_W-1:0] res_data = 12'h000;
  logic narrow_sel = 1'b0;
  logic ptr_load, wr_en, rd_en, int_pin, filt_en;
  logic [PTR_W-1:0] ptr_value;
  logic [7:0] wr_byte, rd_wide, rd_narrow, sb;
  logic [7:0] chan_sel, timer_q;
  logic [15:0] w, last_word;
  int mismatches = 0;
  int cmp_count = 0;
  int up[4], lo[4], hy[4], status, cfg;
  bit hi_a[4], lo_a[4];

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  alc_result_limit #(.RES_BITS(12)) uut (.ref_clk(ref_clk), .rst(rst), .ptr_load(ptr_load),
    .ptr_value(ptr_value), .wr_en(wr_en), .wr_byte(wr_byte), .rd_en(rd_en), .rd_byte(rd_wide),
    .conv_busy(conv_busy), .res_valid(res_valid), .res_channel(res_channel),
    .res_data(res_data), .cfg_channel_sel(chan_sel), .cfg_filter_en(filt_en),
    .cycle_timer(timer_q), .int_pin(int_pin));
  // narrow variant shares the bus; only its read data is looked at
  alc_result_limit #(.RES_BITS(10)) uut_narrow (.ref_clk(ref_clk), .rst(rst),
    .ptr_load(ptr_load), .ptr_value(ptr_value), .wr_en(wr_en), .wr_byte(wr_byte),
    .rd_en(rd_en), .rd_byte(rd_narrow), .conv_busy(conv_busy), .res_valid(res_valid),
    .res_channel(res_channel), .res_data(res_data), .cfg_channel_sel(), .cfg_filter_en(),
    .cycle_timer(), .int_pin());
  alc_host_model host (.ref_clk(ref_clk), .ptr_load(ptr_load), .ptr_value(ptr_value),
    .wr_en(wr_en), .wr_byte(wr_byte), .rd_en(rd_en),
    .rd_byte(narrow_sel ? rd_narrow : rd_wide));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_pin(input logic exp);
    cmp_count++;
    if (int_pin !== exp)
    begin
      mismatches++;
      $display("ERROR int_pin expected %b seen %b", exp, int_pin);
    end
  endtask

  function automatic logic [PTR_W-1:0] lim_idx(input int k, input int kind);
    return PTR_W'(4 + 3 * k + kind);
  endfunction

  function automatic bit any_alert();
    return hi_a[0] | hi_a[1] | hi_a[2] | hi_a[3] | lo_a[0] | lo_a[1] | lo_a[2] | lo_a[3];
  endfunction

  // pin level from mode and polarity
  function automatic logic exp_pin();
    bit act;
    act = (cfg[2:1] == 2) ? any_alert() : (cfg[2:1] == 1) ? conv_busy : 1'b0;
    return cfg[0] ? act : !act;
  endfunction

  // drive one result, update the reference, then compare word, pin and status
  task automatic apply_result(input int ch, input int d);
    @(negedge ref_clk);
    res_valid = 1'b1;
    res_channel = TAG_W'(ch);
    res_data = DATA_W'(d);
    @(negedge ref_clk);
    res_valid = 1'b0;
    res_data = ~res_data;
    repeat (2) @(negedge ref_clk);
    if (ch < NUM_LIMIT_CH)
    begin
      if (d > up[ch])
      begin
        hi_a[ch] = 1'b1;
        status |= 2 << (2 * ch);
      end
      else if (hi_a[ch] && up[ch] - d >= hy[ch])
        hi_a[ch] = 1'b0;
      if (d < lo[ch])
      begin
        lo_a[ch] = 1'b1;
        status |= 1 << (2 * ch);
      end
      else if (lo_a[ch] && d - lo[ch] >= hy[ch])
        lo_a[ch] = 1'b0;
    end
    last_word = {any_alert(), TAG_W'(ch), DATA_W'(d)};
    host.rd16(IDX_RESULT, w);
    check_word("result", last_word, w);
    check_pin(exp_pin());
    host.rd8(IDX_STATUS, sb);
    check_word("status", 16'(status), {8'h00, sb});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    $display("ERROR watchdog expected end seen timeout");
    complete_run();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hb65cf496));
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    cfg = 'h008;
    status = 0;
    for (int k = 0; k < 4; k++)
    begin
      host.rd16(lim_idx(k, 1), w);
      check_word("upper reset", 16'h0fff, w);
      host.rd16(lim_idx(k, 0), w);
      check_word("lower reset", 16'h0000, w);
      host.rd16(lim_idx(k, 2), w);
      check_word("hyst reset", 16'h0008, w);
      narrow_sel = 1'b1;
      host.rd16(lim_idx(k, 1), w);
      check_word("narrow upper reset", 16'h0ffc, w);
      host.rd16(lim_idx(k, 2), w);
      check_word("narrow hyst reset", 16'h0002, w);
      narrow_sel = 1'b0;
    end
    host.rd16(IDX_CFG, w);
    check_word("config reset", 16'h0008, w);
    check_word("filter enable", 16'h0001, {15'h0000, filt_en});
    check_pin(1'b1);
    $display("test reset values done");
    // random limits, top nibble written as ones must read back zero
    for (int k = 0; k < 4; k++)
    begin
      up[k] = 'h400 + $urandom % 'h800 & 'hffc;
      lo[k] = up[k] - 'h300;
      hy[k] = 4 * (1 + $urandom % 8);
      host.wr16(lim_idx(k, 1), 16'hf000 | 16'(up[k]));
      host.wr16(lim_idx(k, 0), 16'hf000 | 16'(lo[k]));
      host.wr16(lim_idx(k, 2), 16'hf000 | 16'(hy[k]));
      host.rd16(lim_idx(k, 1), w);
      check_word("upper", 16'(up[k]), w);
      host.rd16(lim_idx(k, 2), w);
      check_word("hyst", 16'(hy[k]), w);
    end
    $display("test limit registers done");
    // alert mode at both polarities with results near the limits
    for (int p = 0; p < 2; p++)
    begin
      cfg = 'hffc | p;
      host.wr16(IDX_CFG, 16'(cfg));
      host.rd16(IDX_CFG, w);
      check_word("config", 16'(cfg), w);
      check_word("channel select", 16'h00ff, {8'h00, chan_sel});
      for (int i = 0; i < 40; i++)
      begin
        int ch;
        ch = $urandom % 8;
        apply_result(ch, lo[ch % 4] - 16 + $urandom % (up[ch % 4] - lo[ch % 4] + 32));
      end
    end
    $display("test alert mode done");
    // clear code while an alert stands
    apply_result(0, up[0] + 1);
    host.wr16(IDX_CFG, 16'(cfg | 'h6));
    hi_a = '{default: 0};
    lo_a = '{default: 0};
    status = 0;
    repeat (2) @(negedge ref_clk);
    host.rd16(IDX_CFG, w);
    check_word("config after clear", 16'(cfg), w);
    host.rd16(IDX_RESULT, w);
    check_word("result after clear", {1'b0, last_word[14:0]}, w);
    host.rd8(IDX_STATUS, sb);
    check_word("status after clear", 16'h0000, {8'h00, sb});
    check_pin(exp_pin());
    $display("test clear code done");
    // status writes: only all ones clears; result word ignores writes
    apply_result(1, lo[1] - 1);
    host.wr8(IDX_STATUS, 8'h55);
    host.rd8(IDX_STATUS, sb);
    check_word("status kept", 16'(status), {8'h00, sb});
    host.wr8(IDX_STATUS, 8'hff);
    status = 0;
    host.rd8(IDX_STATUS, sb);
    check_word("status cleared", 16'h0000, {8'h00, sb});
    host.wr16(IDX_RESULT, 16'h1234);
    host.rd16(IDX_RESULT, w);
    check_word("result read only", last_word, w);
    host.wr8(IDX_TIMER, 8'hc5);
    host.rd8(IDX_TIMER, sb);
    check_word("timer", 16'h00c5, {8'h00, sb});
    check_word("timer output", 16'h00c5, {8'h00, timer_q});
    $display("test status clear done");
    // pin off and busy at both polarities, with an alert still standing
    for (int m = 0; m < 4; m++)
    begin
      cfg = 'h008 | (m >> 1) << 1 | (m & 1);
      host.wr16(IDX_CFG, 16'(cfg));
      conv_busy = 1'b1;
      repeat (3) @(negedge ref_clk);
      check_pin(exp_pin());
      conv_busy = 1'b0;
      repeat (3) @(negedge ref_clk);
      check_pin(exp_pin());
    end
    $display("test busy and off modes done");
    // narrow variant result keeps its low two bits zero
    apply_result(5, 'hfff);
    narrow_sel = 1'b1;
    host.rd16(IDX_RESULT, w);
    check_word("narrow low bits", 16'h0000, {14'h0, w[1:0]});
    narrow_sel = 1'b0;
    $display("test narrow result done");
    complete_run();
  end
endmodule
